// File: design/lmr_regs.sv
module lmr_regs (
  // Clock, reset and enable
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            ce,
  // Command buffer
  input  wire logic            cmd_we,
  input  wire logic [7:0]      cmd_byte,
  // Write buffer lanes and write command
  input  wire logic [2:0]      wbuf_lane_we,
  input  wire logic [7:0]      wbuf_byte,
  input  wire logic            reg_write_cmd,
  // Read buffer
  output logic [23:0]          rbuf_data,
  // Motion core monitors
  input  wire logic [3:0]      seq_phase,
  input  wire lmr_pkg::lmr_mon_t mon,
  // Port level register
  input  wire logic            port_level_we,
  input  wire logic [3:0]      port_level_wdata,
  output logic [3:0]           port_level_rdata,
  // Multiplexed terminals
  input  wire logic [3:0]      term_in,
  output logic [3:0]           term_out,
  output logic [3:0]           term_oe,
  // Configuration toward the motion core
  output lmr_pkg::lmr_cfg_t    cfg,
  output lmr_pkg::lmr_cmds_t   cmds
);
  import lmr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [23:0]        wbuf_q;
  logic [23:0]        pulse_q;
  logic [W_SPEED-1:0] low_q;
  logic [W_SPEED-1:0] high_q;
  logic [W_RAMP-1:0]  ramp_q;
  logic [W_MULT-1:0]  mult_q;
  logic [23:0]        slow_q;
  logic [W_IDLE-1:0]  idle_q;
  logic [15:0]        env_q;
  logic [7:0]         start_q;
  logic [7:0]         ctrl_q;
  logic [7:0]         regsel_q;
  logic [7:0]         outmode_q;
  logic [3:0]         lvl_q;
  logic [23:0]        rbuf_q;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire logic [2:0]  sel       = regsel_q[2:0];
  wire logic [1:0]  cmd_class = cmd_byte[7:6];
  wire logic        port_mode = env_q[ENV_PORT_FN];
  wire logic [3:0]  dir_in    = env_q[ENV_DIR+3:ENV_DIR];
  // A direction bit of 0 makes an output; all are ignored in phase use.
  wire logic [3:0]  out_mask  = port_mode ? ~dir_in : 4'hf;
  wire logic        commit    = reg_write_cmd;
  wire logic [15:0] status    = {mon.status_high, seq_phase,
                                 mon.status_low};

  // Write buffer lane i holds bits 8*i+7 to 8*i.
  function automatic logic [23:0] lane_load(input logic [23:0] cur,
                                            input logic [2:0]  we,
                                            input logic [7:0]  b);
    logic [23:0] r;
    r = cur;
    for (int i = 0; i < 3; i++)
      if (we[i])
        r[8*i +: 8] = b;
    return r;
  endfunction

  function automatic logic wr_to(input logic [2:0] code);
    return commit && (sel == code);
  endfunction

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  logic [23:0] rd_mux;
  always_comb
  begin
    unique case (sel)
      SEL_PULSE: rd_mux = pulse_q;
      SEL_LOW:   rd_mux = {start_q, 3'h0, low_q};
      SEL_HIGH:  rd_mux = {ctrl_q, 3'h0, high_q};
      SEL_RAMP:  rd_mux = {regsel_q, ramp_q};
      SEL_MULT:  rd_mux = {outmode_q, 6'h00, mult_q};
      SEL_SLOW:  rd_mux = {env_q[7:0], slow_q[15:0]};
      SEL_IDLE:  rd_mux = {mon.current_speed, 5'h00, idle_q};
      SEL_ENV:   rd_mux = {mon.idle_counter, status};
    endcase
  end

  // ----------------------------------------------------------------
  // Next values of the port and environment state
  // ----------------------------------------------------------------
  // Input terminals keep their stored level so a later direction change
  // does not glitch them to a stale value written while they were inputs.
  wire logic [3:0] lvl_d =
    (lvl_q & ~out_mask) | (port_level_wdata & out_mask);
  // The reserved top byte of the environment is never stored; the host
  // keeps it at zero.
  wire logic [15:0] env_d = wbuf_q[15:0];

  // ----------------------------------------------------------------
  // Command buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      start_q   <= RST_CMD;
      ctrl_q    <= RST_CMD;
      regsel_q  <= RST_CMD;
      outmode_q <= RST_CMD;
    end
    else if (ce && cmd_we)
    begin
      unique case (cmd_class)
        CMD_START:  start_q   <= cmd_byte;
        CMD_CTRL:   ctrl_q    <= cmd_byte;
        CMD_REGSEL: regsel_q  <= cmd_byte;
        CMD_OUTPUT: outmode_q <= cmd_byte;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write buffer and read buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wbuf_q <= RST_WORD;
      rbuf_q <= RST_WORD;
    end
    else if (ce)
    begin
      wbuf_q <= lane_load(wbuf_q, wbuf_lane_we, wbuf_byte);
      rbuf_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Registers, committed by the write command
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pulse_q <= RST_WORD;
      low_q   <= RST_WORD[W_SPEED-1:0];
      high_q  <= RST_WORD[W_SPEED-1:0];
      ramp_q  <= RST_WORD[W_RAMP-1:0];
      mult_q  <= RST_WORD[W_MULT-1:0];
      slow_q  <= RST_WORD;
      idle_q  <= RST_WORD[W_IDLE-1:0];
      env_q   <= RST_ENV;
    end
    else if (ce)
    begin
      if (wr_to(SEL_PULSE))
        pulse_q <= wbuf_q;
      if (wr_to(SEL_LOW))
        low_q <= wbuf_q[W_SPEED-1:0];
      if (wr_to(SEL_HIGH))
        high_q <= wbuf_q[W_SPEED-1:0];
      if (wr_to(SEL_RAMP))
        ramp_q <= wbuf_q[W_RAMP-1:0];
      if (wr_to(SEL_MULT))
        mult_q <= wbuf_q[W_MULT-1:0];
      if (wr_to(SEL_SLOW))
        slow_q <= wbuf_q;
      if (wr_to(SEL_IDLE))
        idle_q <= wbuf_q[W_IDLE-1:0];
      if (wr_to(SEL_ENV))
        env_q <= env_d;
    end
  end

  // ----------------------------------------------------------------
  // Port level register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      lvl_q <= RST_LVL;
    else if (ce && port_level_we)
      lvl_q <= lvl_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rbuf_data        = rbuf_q;
  assign port_level_rdata = term_in;
  assign term_out = port_mode ? lvl_q : seq_phase;
  assign term_oe  = out_mask;

  assign cfg.pulse_count          = pulse_q;
  assign cfg.low_speed            = low_q;
  assign cfg.high_speed           = high_q;
  assign cfg.ramp_rate            = ramp_q;
  assign cfg.multiplier           = mult_q;
  assign cfg.slowdown_point       = slow_q;
  assign cfg.idle_pulses          = idle_q;
  assign cfg.environment          = env_q;
  assign cfg.auto_slowdown_enable = env_q[ENV_AUTO_SLOW];

  assign cmds.start_mode      = start_q;
  assign cmds.control_mode    = ctrl_q;
  assign cmds.register_select = regsel_q;
  assign cmds.output_mode     = outmode_q;

endmodule // lmr_regs

// File: design/lmr_pkg.sv
package lmr_pkg;

  // ----------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_PULSE = 3'h0;
  localparam logic [2:0] SEL_LOW   = 3'h1;
  localparam logic [2:0] SEL_HIGH  = 3'h2;
  localparam logic [2:0] SEL_RAMP  = 3'h3;
  localparam logic [2:0] SEL_MULT  = 3'h4;
  localparam logic [2:0] SEL_SLOW  = 3'h5;
  localparam logic [2:0] SEL_IDLE  = 3'h6;
  localparam logic [2:0] SEL_ENV   = 3'h7;

  // ----------------------------------------------------------------
  // Command byte classes in bits 7 to 6
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_START  = 2'h0;
  localparam logic [1:0] CMD_CTRL   = 2'h1;
  localparam logic [1:0] CMD_REGSEL = 2'h2;
  localparam logic [1:0] CMD_OUTPUT = 2'h3;

  // ----------------------------------------------------------------
  // Field widths and environment bit positions
  // ----------------------------------------------------------------
  localparam int W_SPEED = 13;
  localparam int W_RAMP  = 16;
  localparam int W_MULT  = 10;
  localparam int W_IDLE  = 3;
  localparam int ENV_AUTO_SLOW = 3;
  localparam int ENV_PORT_FN   = 11;
  localparam int ENV_DIR       = 12;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [23:0] RST_WORD = 24'h00_0000;
  localparam logic [15:0] RST_ENV  = 16'h0000;
  localparam logic [7:0]  RST_CMD  = 8'h00;
  localparam logic [3:0]  RST_LVL  = 4'h0;

  typedef struct packed {
    logic [23:0]        pulse_count;
    logic [W_SPEED-1:0] low_speed;
    logic [W_SPEED-1:0] high_speed;
    logic [W_RAMP-1:0]  ramp_rate;
    logic [W_MULT-1:0]  multiplier;
    logic [23:0]        slowdown_point;
    logic [W_IDLE-1:0]  idle_pulses;
    logic [15:0]        environment;
    logic               auto_slowdown_enable;
  } lmr_cfg_t;

  typedef struct packed {
    logic [7:0] start_mode;
    logic [7:0] control_mode;
    logic [7:0] register_select;
    logic [7:0] output_mode;
  } lmr_cmds_t;

  typedef struct packed {
    logic [15:0] current_speed;
    logic [7:0]  idle_counter;
    logic [3:0]  status_high;
    logic [7:0]  status_low;
  } lmr_mon_t;

endpackage

// File: bench/lmr_sva.sv
module lmr_sva
  import lmr_pkg::*;
(
  // Clock, reset and enable
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                ce,
  // Watched state and monitors
  input wire lmr_pkg::lmr_cfg_t   cfg,
  input wire lmr_pkg::lmr_cmds_t  cmds,
  input wire lmr_pkg::lmr_mon_t   mon,
  input wire logic [3:0]          seq_phase,
  input wire logic [23:0]         rbuf_data,
  // Terminals
  input wire logic [3:0]          term_in,
  input wire logic [3:0]          term_out,
  input wire logic [3:0]          term_oe,
  input wire logic [3:0]          port_level_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic [2:0] sel;
  assign sel = cmds.register_select[2:0];
  AST_PHASE: assert property (!cfg.environment[11] |->
    term_oe == 4'hf && term_out == seq_phase) else $error("phase pins");
  AST_DIR: assert property (cfg.environment[11] |->
    term_oe == ~cfg.environment[15:12]) else $error("port direction");
  AST_LVL: assert property (port_level_rdata == term_in)
    else $error("port level read");
  AST_PULSE: assert property (ce && sel == SEL_PULSE |=>
    rbuf_data == $past(cfg.pulse_count)) else $error("pulse read");
  AST_LOW: assert property (ce && sel == SEL_LOW |=>
    rbuf_data == {$past(cmds.start_mode), 3'h0, $past(cfg.low_speed)})
    else $error("low speed read");
  AST_SLOW: assert property (ce && sel == SEL_SLOW |=>
    rbuf_data == {$past(cfg.environment[7:0]),
    $past(cfg.slowdown_point[15:0])}) else $error("slowdown read");
  AST_IDLE: assert property (ce && sel == SEL_IDLE |=>
    rbuf_data == {$past(mon.current_speed), 5'h0, $past(cfg.idle_pulses)})
    else $error("idle read");
  AST_ENV: assert property (ce && sel == SEL_ENV |=>
    rbuf_data == {$past(mon.idle_counter), $past(mon.status_high),
    $past(seq_phase), $past(mon.status_low)}) else $error("status read");
  AST_AUTO_SLOW: assert property (cfg.auto_slowdown_enable ==
    cfg.environment[ENV_AUTO_SLOW]) else $error("auto slowdown");
endmodule // lmr_sva

bind lmr_regs lmr_sva u_sva (.clk(clk), .reset(reset), .ce(ce), .cfg(cfg),
  .cmds(cmds), .mon(mon), .seq_phase(seq_phase), .rbuf_data(rbuf_data),
  .term_in(term_in), .term_out(term_out), .term_oe(term_oe),
  .port_level_rdata(port_level_rdata));

// File: bench/lmr_host.sv
module lmr_host (
  input  wire logic clk,
  output logic       cmd_we,
  output logic [7:0] cmd_byte,
  output logic [2:0] wbuf_lane_we,
  output logic [7:0] wbuf_byte,
  output logic       reg_write_cmd,
  output logic       port_level_we,
  output logic [3:0] port_level_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import lmr_pkg::*;
  initial {cmd_we, cmd_byte, wbuf_lane_we, wbuf_byte} = '0;
  initial {reg_write_cmd, port_level_we, port_level_wdata} = '0;
  // Released data lines show the inverse so stale values never pass.
  task automatic cmd(input logic [7:0] b);
    @(negedge clk); cmd_we = 1'b1; cmd_byte = b;
    @(negedge clk); cmd_we = 1'b0; cmd_byte = ~b;
  endtask
  task automatic wr(input logic [2:0] c, input logic [23:0] d);
    logic [23:0] v;
    v = d;
    if (c == SEL_ENV) v[23:16] = 8'h00;
    cmd({5'h10, c});
    for (int i = 2; i >= 0; i--)
    begin
      @(negedge clk);
      wbuf_lane_we = 3'(1 << i);
      wbuf_byte = v[8*i +: 8];
    end
    @(negedge clk); wbuf_lane_we = 3'h0; wbuf_byte = ~wbuf_byte;
    reg_write_cmd = 1'b1;
    @(negedge clk); reg_write_cmd = 1'b0;
  endtask
  task automatic lvl(input logic [3:0] v);
    @(negedge clk); port_level_we = 1'b1; port_level_wdata = v;
    @(negedge clk); port_level_we = 1'b0; port_level_wdata = ~v;
  endtask
endmodule // lmr_host

// File: bench/tb_legacy_mode_register_access.sv
module tb_legacy_mode_register_access;
  timeunit 1ns;
  timeprecision 1ns;
  import lmr_pkg::*;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1;
  logic [3:0] ext = 4'h0, seq = 4'h6;
  lmr_mon_t mon = {16'hbeef, 8'h3c, 4'ha, 8'h5b};
  logic cmd_we, reg_write_cmd, port_level_we;
  logic [7:0] cmd_byte, wbuf_byte;
  logic [2:0] wbuf_lane_we;
  logic [3:0] port_level_wdata, port_level_rdata, term_in, term_out, term_oe;
  logic [23:0] rbuf_data;
  lmr_cfg_t cfg;
  lmr_cmds_t cmds;
  int errors = 0, num_checks = 0;
  // Input-configured pins follow the outside level, driven pins the device.
  assign term_in = (term_oe & term_out) | (~term_oe & ext);
  initial forever #50 clk = ~clk;
  lmr_host host_u (.clk(clk), .cmd_we(cmd_we), .cmd_byte(cmd_byte),
    .wbuf_lane_we(wbuf_lane_we), .wbuf_byte(wbuf_byte),
    .reg_write_cmd(reg_write_cmd), .port_level_we(port_level_we),
    .port_level_wdata(port_level_wdata));
  lmr_regs dut_u (.clk(clk), .reset(reset), .ce(ce), .cmd_we(cmd_we),
    .cmd_byte(cmd_byte), .wbuf_lane_we(wbuf_lane_we), .wbuf_byte(wbuf_byte),
    .reg_write_cmd(reg_write_cmd), .rbuf_data(rbuf_data), .seq_phase(seq),
    .mon(mon), .port_level_we(port_level_we),
    .port_level_wdata(port_level_wdata), .port_level_rdata(port_level_rdata),
    .term_in(term_in), .term_out(term_out), .term_oe(term_oe), .cfg(cfg),
    .cmds(cmds));
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++; $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task rd(input logic [2:0] c, input logic [23:0] e);
    host_u.cmd({5'h10, c});
    repeat (2) @(negedge clk);
    chk("rbuf", e, rbuf_data);
  endtask
  task t_pulse;
    host_u.wr(SEL_PULSE, 24'h123456);
    chk("pulse", 24'h123456, cfg.pulse_count);
    rd(SEL_PULSE, 24'h123456);
    host_u.wr(SEL_PULSE, 24'hffffff);
    rd(SEL_PULSE, 24'hffffff);
    $display("test pulse done");
  endtask
  task t_map;
    host_u.cmd(8'h15); host_u.cmd(8'h5a); host_u.cmd(8'he0);
    for (int c = 1; c < 7; c++) host_u.wr(3'(c), 24'hffffff);
    host_u.wr(SEL_ENV, 24'hffa80b);
    chk("env", 24'h00a80b, {8'h0, cfg.environment});
    rd(SEL_LOW, {8'h15, 3'h0, 13'h1fff});
    rd(SEL_HIGH, {8'h5a, 3'h0, 13'h1fff});
    rd(SEL_RAMP, {8'h83, 16'hffff});
    rd(SEL_MULT, {8'he0, 6'h0, 10'h3ff});
    rd(SEL_SLOW, {8'h0b, 16'hffff});
    rd(SEL_IDLE, {16'hbeef, 5'h0, 3'h7});
    rd(SEL_ENV, {8'h3c, 4'ha, 4'h6, 8'h5b});
    chk("auto_slowdown_enable", 24'h1, {23'h0, cfg.auto_slowdown_enable});
    $display("test map done");
  endtask
  task t_port;
    chk("oe", 24'h5, {20'h0, term_oe});
    host_u.lvl(4'hf);
    chk("level", 24'h5, {20'h0, port_level_rdata});
    ext = 4'hf;
    host_u.lvl(4'h0);
    chk("level", 24'ha, {20'h0, port_level_rdata});
    host_u.wr(SEL_ENV, 24'h00f000);
    chk("oe", 24'hf, {20'h0, term_oe});
    chk("out", 24'h6, {20'h0, term_out});
    // A low clock enable must freeze the command, buffer and registers.
    ce = 1'b0;
    host_u.wr(SEL_PULSE, 24'h000001);
    ce = 1'b1;
    chk("freeze", 24'hffffff, cfg.pulse_count);
    $display("test port done");
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_pulse;
    t_map;
    t_port;
    final_report;
  end
  // Whole run needs about 130 cycles; this cuts off a hang.
  initial
  begin
    #200000;
    errors++;
    final_report;
  end
endmodule // tb_legacy_mode_register_access
